// ### double_and_range_compare_unit.sv
/*
 * double-word compare and range block compare datapath with its own
 * operand fetch sequencer and data memory port.
 * assumes the instruction sequencer pulses start_in while busy_out is
 * low, and the data memory answers a read one cycle after mem_rd_out.
 */
//
// Function
// - condition false: double compare changes no flag, touches no memory
// - each operand is next word as high half, given word as low half
// - greater flag set only when first combined value exceeds second
// - equal flag set only when both combined values are identical
// - less flag set only when first combined value is below second
// - error when indirect pointer is not bcd or beyond data area
// - compare flags hold until a later compare rewrites them
// - condition false: range compare leaves result word and flags
// - pair k at block base plus 2k gives result bit k
// - result bit set when lower <= value <= upper, limits inclusive
// - every result bit outside its range is cleared, whole word written
// - error when block base through base plus 31 passes area end
// - less, greater, equal flags read as bits 7, 5, 6 of word 255
`timescale 1ns/1ps

module double_and_range_compare_unit (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic        start_in,
   input  wire logic        op_sel_in,
   input  wire logic        exec_cond_in,
   input  wire logic [15:0] first_addr_in,
   input  wire logic        first_indirect_in,
   input  wire logic [15:0] second_addr_in,
   input  wire logic        second_indirect_in,
   input  wire logic [15:0] result_addr_in,
   input  wire logic [15:0] area_end_in,
   input  wire logic [15:0] mem_rdata_in,
   output logic      [15:0] mem_addr_out,
   output logic             mem_rd_out,
   output logic             mem_wr_out,
   output logic      [15:0] mem_wdata_out,
   output logic             greater_flag_out,
   output logic             equal_flag_out,
   output logic             less_flag_out,
   output logic             error_flag_out,
   output logic      [15:0] special_flag_area_out,
   output logic             busy_out,
   output logic             done_out
);

   typedef struct packed {
      compare_unit_pkg::fsm_state_t st;
      logic        op;
      logic [1:0]  ind;
      logic [15:0] a0;
      logic [15:0] a1;
      logic [15:0] res_addr;
      logic        res_sel;
      logic [5:0]  idx;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [15:0] w2;
      logic [15:0] w3;
      logic [15:0] mask;
      logic        greater;
      logic        equal;
      logic        less;
      logic        err;
      logic [15:0] flag_word;
      logic [15:0] mem_addr;
      logic        mem_rd;
      logic        mem_wr;
      logic [15:0] mem_wdata;
      logic        busy;
      logic        done;
   } unit_state_t;

   unit_state_t q;
   unit_state_t d;

   logic [15:0] ptr_addr;
   logic        ptr_err;

   // ****************************************************************
   // indirect pointer resolution
   // ****************************************************************
   pointer_resolver resolver (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .ptr_word_in (mem_rdata_in),
      .area_end_in (area_end_in),
      .addr_out    (ptr_addr),
      .err_out     (ptr_err)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic past_end(input logic [15:0] base,
                                     input logic [16:0] ofs,
                                     input logic [15:0] last);
      past_end = ({1'b0, base} + ofs) > {1'b0, last};
   endfunction

   function automatic logic [15:0] flags_word(input logic g,
                                              input logic e,
                                              input logic l);
      logic [15:0] w;
      w = 16'h0000;
      w[compare_unit_pkg::GREATER_BIT] = g;
      w[compare_unit_pkg::EQUAL_BIT]   = e;
      w[compare_unit_pkg::LESS_BIT]    = l;
      flags_word = w;
   endfunction

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      logic [31:0] v1;
      logic [31:0] v2;
      logic [5:0]  k;
      logic [5:0]  last_idx;
      v1 = 32'h00000000;
      v2 = 32'h00000000;
      k = 6'h00;
      last_idx = 6'h00;
      d = q;
      d.mem_rd = 1'b0;
      d.mem_wr = 1'b0;
      d.done   = 1'b0;
      case (q.st)
         compare_unit_pkg::ST_IDLE: begin
            if (start_in) begin
               if (!exec_cond_in) begin
                  d.done = 1'b1;
               end else begin
                  d.op       = op_sel_in;
                  d.a0       = first_addr_in;
                  d.a1       = second_addr_in;
                  d.ind      = {second_indirect_in, first_indirect_in};
                  d.res_addr = result_addr_in;
                  d.res_sel  = 1'b0;
                  d.err      = 1'b0;
                  d.busy     = 1'b1;
                  d.st       = compare_unit_pkg::ST_RES;
               end
            end
         end
         compare_unit_pkg::ST_RES: begin
            if (q.ind[q.res_sel]) begin
               d.mem_rd   = 1'b1;
               d.mem_addr = q.res_sel ? q.a1 : q.a0;
               d.st       = compare_unit_pkg::ST_PTR;
            end else if (!q.res_sel) begin
               d.res_sel = 1'b1;
            end else begin
               d.st = compare_unit_pkg::ST_BOUND;
            end
         end
         compare_unit_pkg::ST_PTR: begin
            d.st = compare_unit_pkg::ST_PTR_WAIT;
         end
         compare_unit_pkg::ST_PTR_WAIT: begin
            d.st = compare_unit_pkg::ST_PTR_CHK;
         end
         compare_unit_pkg::ST_PTR_CHK: begin
            if (ptr_err) begin
               d.err  = 1'b1;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.st   = compare_unit_pkg::ST_IDLE;
            end else begin
               if (q.res_sel) begin
                  d.a1 = ptr_addr;
                  d.st = compare_unit_pkg::ST_BOUND;
               end else begin
                  d.a0      = ptr_addr;
                  d.res_sel = 1'b1;
                  d.st      = compare_unit_pkg::ST_RES;
               end
            end
         end
         compare_unit_pkg::ST_BOUND: begin
            d.idx  = compare_unit_pkg::IDX_RESET;
            d.mask = compare_unit_pkg::WORD_RESET;
            d.st   = compare_unit_pkg::ST_FETCH;
            if (q.op == compare_unit_pkg::OP_RANGE) begin
               if (past_end(q.a1, compare_unit_pkg::BLOCK_LAST_OFS,
                            area_end_in)) begin
                  d.err  = 1'b1;
                  d.busy = 1'b0;
                  d.done = 1'b1;
                  d.st   = compare_unit_pkg::ST_IDLE;
               end
            end else if (past_end(q.a0, compare_unit_pkg::HIGH_WORD_OFS,
                                  area_end_in) ||
                         past_end(q.a1, compare_unit_pkg::HIGH_WORD_OFS,
                                  area_end_in)) begin
               d.err  = 1'b1;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.st   = compare_unit_pkg::ST_IDLE;
            end
         end
         compare_unit_pkg::ST_FETCH: begin
            d.mem_rd = 1'b1;
            d.st     = compare_unit_pkg::ST_WAIT;
            if (q.op == compare_unit_pkg::OP_RANGE) begin
               // value first, then block words base .. base+31
               d.mem_addr = (q.idx == 6'h00) ? q.a0
                          : q.a1 + 16'(q.idx - 6'h01);
            end else begin
               // low word at given address, high word at the next
               d.mem_addr = (q.idx[1] ? q.a1 : q.a0)
                          + 16'(q.idx[0]);
            end
         end
         compare_unit_pkg::ST_WAIT: begin
            d.st = compare_unit_pkg::ST_CAP;
         end
         compare_unit_pkg::ST_CAP: begin
            last_idx = (q.op == compare_unit_pkg::OP_RANGE)
                     ? compare_unit_pkg::RANGE_READS - 6'h01
                     : compare_unit_pkg::DOUBLE_READS - 6'h01;
            if (q.op == compare_unit_pkg::OP_RANGE) begin
               k = q.idx - 6'h01;
               if (q.idx == 6'h00) begin
                  d.w0 = mem_rdata_in;
               end else if (!k[0]) begin
                  d.w1 = mem_rdata_in;
               end else begin
                  // inclusive limits, bit k of pair k
                  d.mask[k[4:1]] = (q.w0 >= q.w1) &&
                                   (q.w0 <= mem_rdata_in);
               end
            end else begin
               case (q.idx[1:0])
                  2'h0: d.w0 = mem_rdata_in;
                  2'h1: d.w1 = mem_rdata_in;
                  2'h2: d.w2 = mem_rdata_in;
                  default: d.w3 = mem_rdata_in;
               endcase
            end
            if (q.idx == last_idx) begin
               d.st = compare_unit_pkg::ST_FINISH;
            end else begin
               d.idx = q.idx + 6'h01;
               d.st  = compare_unit_pkg::ST_FETCH;
            end
         end
         compare_unit_pkg::ST_FINISH: begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st   = compare_unit_pkg::ST_IDLE;
            if (q.op == compare_unit_pkg::OP_RANGE) begin
               // whole result word rewritten
               d.mem_wr    = 1'b1;
               d.mem_addr  = q.res_addr;
               d.mem_wdata = q.mask;
            end else begin
               v1 = {q.w1, q.w0};
               v2 = {q.w3, q.w2};
               // unsigned, one flag only
               d.greater   = v1 > v2;
               d.equal     = v1 == v2;
               d.less      = v1 < v2;
               d.flag_word = flags_word(v1 > v2, v1 == v2,
                                        v1 < v2);
            end
         end
         default: begin
            d = '0;
         end
      endcase
   end

   // compare flags change only in the finish step of a double compare
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign mem_addr_out          = q.mem_addr;
   assign mem_rd_out            = q.mem_rd;
   assign mem_wr_out            = q.mem_wr;
   assign mem_wdata_out         = q.mem_wdata;
   assign greater_flag_out      = q.greater;
   assign equal_flag_out        = q.equal;
   assign less_flag_out         = q.less;
   assign error_flag_out        = q.err;
   assign special_flag_area_out = q.flag_word;
   assign busy_out              = q.busy;
   assign done_out              = q.done;

endmodule

// ### compare_unit_pkg.sv
/*
 * constants and types shared by the double-word and range block compare
 * unit and its property checker.
 * assumes one clock domain and a word-wide data memory with a one-cycle
 * read latency.
 */
package compare_unit_pkg;

   // ****************************************************************
   // operation select
   // ****************************************************************
   localparam logic       OP_DOUBLE        = 1'b0;
   localparam logic       OP_RANGE         = 1'b1;

   // ****************************************************************
   // word counts
   // ****************************************************************
   localparam logic [5:0] DOUBLE_READS     = 6'h04;
   localparam logic [5:0] RANGE_READS      = 6'h21;
   localparam logic [5:0] RANGE_COUNT      = 6'h10;
   localparam logic [16:0] BLOCK_LAST_OFS  = 17'h0001F;
   localparam logic [16:0] HIGH_WORD_OFS   = 17'h00001;

   // ****************************************************************
   // special flag word layout
   // ****************************************************************
   localparam logic [15:0] SPECIAL_FLAG_WORD = 16'h00FF;
   localparam int          GREATER_BIT       = 5;
   localparam int          EQUAL_BIT         = 6;
   localparam int          LESS_BIT          = 7;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] WORD_RESET      = 16'h0000;
   localparam logic [5:0]  IDX_RESET       = 6'h00;

   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_RES,
      ST_PTR,
      ST_PTR_WAIT,
      ST_PTR_CHK,
      ST_BOUND,
      ST_FETCH,
      ST_WAIT,
      ST_CAP,
      ST_FINISH
   } fsm_state_t;

endpackage

// ### pointer_resolver.sv
/*
 * resolves an indirect pointer word: checks that it is valid bcd,
 * converts it to a binary word address and checks it against the last
 * address of the data memory area.
 * assumes the pointer word is presented for one cycle; results appear,
 * registered, on the following cycle.
 */
`timescale 1ns/1ps

module pointer_resolver (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic [15:0] ptr_word_in,
   input  wire logic [15:0] area_end_in,
   output logic      [15:0] addr_out,
   output logic             err_out
);

   typedef struct packed {
      logic [15:0] addr;
      logic        err;
   } res_state_t;

   res_state_t q;
   res_state_t d;

   // ****************************************************************
   // bcd digit check
   // ****************************************************************
   function automatic logic digit_bad(input logic [3:0] dig);
      digit_bad = (dig > 4'h9);
   endfunction

   always_comb begin
      logic [15:0] bin;
      logic        bad;
      bin = 16'h0000;
      bad = 1'b0;
      for (int i = 0; i < 4; i++) begin
         bad = bad | digit_bad(ptr_word_in[i*4 +: 4]);
      end
      bin = 16'(ptr_word_in[15:12]) * 16'h03E8
          + 16'(ptr_word_in[11:8]) * 16'h0064
          + 16'(ptr_word_in[7:4]) * 16'h000A
          + 16'(ptr_word_in[3:0]);
      d.addr = bin;
      // not bcd, or past the data area: unresolved
      d.err  = bad | (bin > area_end_in);
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign addr_out = q.addr;
   assign err_out  = q.err;

endmodule

// ### double_and_range_compare_unit_properties.sv
/* port checker for the double-word and range block compare unit.
   assumes it is bound to the unit: one clock, sync active-low reset. */
`timescale 1ns/1ps
module double_and_range_compare_unit_properties (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        start_in,
   input wire logic        op_sel_in,
   input wire logic        exec_cond_in,
   input wire logic [15:0] second_addr_in,
   input wire logic        second_indirect_in,
   input wire logic [15:0] area_end_in,
   input wire logic [15:0] mem_rdata_in,
   input wire logic        mem_rd_out,
   input wire logic        mem_wr_out,
   input wire logic        greater_flag_out,
   input wire logic        equal_flag_out,
   input wire logic        less_flag_out,
   input wire logic        error_flag_out,
   input wire logic [15:0] special_flag_area_out,
   input wire logic        busy_out,
   input wire logic        done_out
);
   // ****************************************************************
   // helper: last four read words and the running operation
   // ****************************************************************
   typedef struct packed {
      logic        rdv;
      logic [63:0] w;
      logic        op;
      logic        ex;
   } hlp_t;
   hlp_t        h_q;
   hlp_t        h_d;
   logic [2:0]  gel;
   logic        dbl_ok;
   assign gel = {greater_flag_out, equal_flag_out, less_flag_out};
   assign dbl_ok = done_out && !error_flag_out && h_q.ex
                   && h_q.op == compare_unit_pkg::OP_DOUBLE;
   always_comb begin
      h_d = h_q;
      h_d.rdv = mem_rd_out;
      if (h_q.rdv)
         h_d.w = {mem_rdata_in, h_q.w[63:16]};
      if (start_in && !busy_out) begin
         h_d.op = op_sel_in;
         h_d.ex = exec_cond_in;
      end
   end
   always_ff @(posedge clk_in)
      h_q <= resetn_in ? h_d : '0;
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_go;
      start_in && !busy_out;
   endsequence
   sequence s_skip;
      s_go ##0 !exec_cond_in;
   endsequence
   sequence s_blk_over;
      s_go ##0 exec_cond_in && op_sel_in && !second_indirect_in
      && {1'b0, second_addr_in} + compare_unit_pkg::BLOCK_LAST_OFS
         > {1'b0, area_end_in};
   endsequence
   property p_skip;
      s_skip |=> done_out && !mem_rd_out && !mem_wr_out
                 && $stable({gel, error_flag_out});
   endproperty
   property p_rel;
      dbl_ok |-> gel == {h_q.w[31:0] > h_q.w[63:32],
                         h_q.w[31:0] == h_q.w[63:32],
                         h_q.w[31:0] < h_q.w[63:32]};
   endproperty
   property p_one;
      dbl_ok |-> $onehot(gel);
   endproperty
   property p_word;
      special_flag_area_out == {8'h00, gel[0], gel[1], gel[2], 5'h00};
   endproperty
   property p_hold;
      $changed(gel) |-> done_out && h_q.op == compare_unit_pkg::OP_DOUBLE;
   endproperty
   property p_blk;
      s_blk_over |-> ##[1:40] done_out && error_flag_out;
   endproperty
   property p_wr;
      done_out && h_q.ex && h_q.op == compare_unit_pkg::OP_RANGE
      && !error_flag_out |-> mem_wr_out;
   endproperty
   property p_err;
      done_out && error_flag_out |-> $stable(gel) && !mem_wr_out;
   endproperty
   a_skip:
      assert property (p_skip) else $error("skipped op changed state");
   a_rel:
      assert property (p_rel) else $error("relation flags wrong");
   a_one:
      assert property (p_one) else $error("relation flags not one-hot");
   a_word:
      assert property (p_word) else $error("flag word layout wrong");
   a_hold:
      assert property (p_hold) else $error("flags moved outside a compare");
   a_blk:
      assert property (p_blk) else $error("block overrun not flagged");
   a_wr:
      assert property (p_wr) else $error("mask word not written");
   a_err:
      assert property (p_err) else $error("error run changed state");
endmodule

bind double_and_range_compare_unit double_and_range_compare_unit_properties
   chk_i (.*);

// ### data_memory_model.sv
/* data memory standing at the far side of the compare unit.
   assumes reads are answered in the cycle after the read strobe. */
`timescale 1ns/1ps
module data_memory_model (
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] rdata_out
);
   logic [15:0] mem [0:255];
   initial rdata_out = 16'h0000;
   // data valid one cycle only, then the bus shows the inverse
   always @(posedge clk_in) begin
      if (rd_in)
         rdata_out <= mem[addr_in[7:0]];
      else
         rdata_out <= ~rdata_out;
      if (wr_in)
         mem[addr_in[7:0]] <= wdata_in;
   end
endmodule

// ### double_and_range_compare_unit_bench.sv
/* self-checking bench for the double-word and range block compare unit.
   assumes the data memory model and the bound property checker. */
`timescale 1ns/1ps
module double_and_range_compare_unit_bench;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        start_in = 1'b0;
   logic        op_sel_in = 1'b0;
   logic        exec_cond_in = 1'b0;
   logic        first_indirect_in = 1'b0;
   logic        second_indirect_in = 1'b0;
   logic [15:0] first_addr_in = 16'h0000;
   logic [15:0] second_addr_in = 16'h0000;
   logic [15:0] result_addr_in = 16'h00FF;
   logic [15:0] area_end_in = 16'h00FF;
   logic [15:0] mem_rdata_in, mem_addr_out, mem_wdata_out;
   logic [15:0] special_flag_area_out, exp_w, g, m, x, lo, hi;
   logic        mem_rd_out, mem_wr_out, greater_flag_out, equal_flag_out;
   logic        less_flag_out, error_flag_out, busy_out, done_out;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          i, k, a, b;

   double_and_range_compare_unit dut (.*);
   data_memory_model mem_i (.clk_in(clk_in), .rd_in(mem_rd_out),
      .wr_in(mem_wr_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .rdata_out(mem_rdata_in));

   initial forever #2.5 clk_in = ~clk_in;
   // ****************************************************************
   // expectation, compare and drive tasks
   // ****************************************************************
   function automatic logic [15:0] fword(input logic [31:0] p, q);
      return {8'h00, p < q, p == q, p > q, 5'h00};
   endfunction
   function automatic logic [15:0] hits(input int v, input int cb);
      logic [15:0] r;
      r = 16'h0000;
      for (int n = 0; n < 16; n++)
         r[n] = mem_i.mem[v] >= mem_i.mem[cb+2*n]
                && mem_i.mem[v] <= mem_i.mem[cb+2*n+1];
      return r;
   endfunction
   task automatic chk1(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", n, e, s);
      end
   endtask
   task automatic chk16(input string n, input logic [15:0] e, s);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic run(input logic op, ex, input logic [15:0] f, s,
                      input logic fi, si);
      int n;
      n = 0;
      @(posedge clk_in);
      start_in <= 1'b1;
      op_sel_in <= op;
      exec_cond_in <= ex;
      first_addr_in <= f;
      second_addr_in <= s;
      first_indirect_in <= fi;
      second_indirect_in <= si;
      @(posedge clk_in);
      start_in <= 1'b0;
      do begin
         @(negedge clk_in);
         n++;
      end while (done_out !== 1'b1 && n < 200);
      if (n >= 200) begin
         bad_count++;
         $display("unexpected done: expected 1, seen %b", done_out);
      end
   endtask
   task automatic dcase(input logic [15:0] f, s, input logic fi, si,
                        input int pa, pb);
      exp_w = fword({mem_i.mem[pa+1], mem_i.mem[pa]},
                    {mem_i.mem[pb+1], mem_i.mem[pb]});
      run(1'b0, 1'b1, f, s, fi, si);
      g = {8'h00, less_flag_out, equal_flag_out, greater_flag_out, 5'h00};
      chk16("flags", exp_w, g);
      chk16("flag word", exp_w, special_flag_area_out);
      chk1("error flag", 1'b0, error_flag_out);
   endtask
   task automatic ecase(input logic op, input logic [15:0] f, s,
                        input logic fi, si);
      m = mem_i.mem[8'hFF];
      run(op, 1'b1, f, s, fi, si);
      chk1("error flag", 1'b1, error_flag_out);
      chk16("flag word", exp_w, special_flag_area_out);
      chk16("result word", m, mem_i.mem[8'hFF]);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hA8AB));
      for (k = 0; k < 256; k++)
         mem_i.mem[k] = 16'($urandom);
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      for (i = 0; i < 20; i++) begin
         a = $urandom_range(0, 254);
         b = (i == 0) ? a : $urandom_range(0, 254);
         if (i == 1)
            mem_i.mem[b+1] = mem_i.mem[a+1];
         if (i == 2) begin
            mem_i.mem[a+1] = 16'h8000;
            mem_i.mem[b+1] = 16'h7FFF;
         end
         dcase(16'(a), 16'(b), 1'b0, 1'b0, a, b);
      end
      mem_i.mem[8'hF0] = 16'h0040;
      mem_i.mem[8'hF1] = 16'h0123;
      dcase(16'h00F0, 16'h00F1, 1'b1, 1'b1, 40, 123);
      $display("test double compare done");
      for (i = 0; i < 10; i++) begin
         b = (i == 0) ? 224 : $urandom_range(0, 223);
         a = (b + 32) % 256;
         x = (i == 1) ? 16'hFFFF : 16'($urandom);
         mem_i.mem[a] = x;
         for (k = 0; k < 32; k += 2) begin
            lo = (k == 2) ? x : (k % 4 == 0) ? 16'($urandom_range(0, x))
                                             : 16'($urandom);
            hi = (k % 8 == 0) ? x : 16'($urandom_range(lo, 65535));
            mem_i.mem[b+k] = lo;
            mem_i.mem[b+k+1] = hi;
         end
         m = hits(a, b);
         run(1'b1, 1'b1, 16'(a), 16'(b), 1'b0, 1'b0);
         chk1("write strobe", 1'b1, mem_wr_out);
         chk16("write address", 16'h00FF, mem_addr_out);
         chk16("write data", m, mem_wdata_out);
         chk16("flag word", exp_w, special_flag_area_out);
         // the write lands at the edge that closes the done cycle
         @(negedge clk_in);
         chk16("mask", m, mem_i.mem[8'hFF]);
      end
      $display("test range compare done");
      mem_i.mem[8'hF2] = 16'h00A0;
      mem_i.mem[8'hF3] = 16'h0300;
      ecase(1'b0, 16'h00F2, 16'h0000, 1'b1, 1'b0);
      ecase(1'b0, 16'h0000, 16'h00F3, 1'b0, 1'b1);
      ecase(1'b0, 16'h00FF, 16'h0000, 1'b0, 1'b0);
      ecase(1'b1, 16'h0000, 16'h00E1, 1'b0, 1'b0);
      $display("test error paths done");
      m = mem_i.mem[8'hFF];
      run(1'b0, 1'b0, 16'h0000, 16'h0002, 1'b0, 1'b0);
      chk16("flag word", exp_w, special_flag_area_out);
      chk1("error flag", 1'b1, error_flag_out);
      run(1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0);
      chk1("write strobe", 1'b0, mem_wr_out);
      chk16("result word", m, mem_i.mem[8'hFF]);
      chk16("flag word", exp_w, special_flag_area_out);
      dcase(16'h0010, 16'h0020, 1'b0, 1'b0, 16, 32);
      $display("test skipped ops done");
      tally_and_finish();
   end
endmodule
